// File: pkg/htc_pkg.sv
package htc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] HTC_OFS_CTRL1 = 12'h110;
	localparam logic [11:0] HTC_OFS_SUPP = 12'h111;
	localparam logic [11:0] HTC_OFS_CTRL2 = 12'h113;
	localparam logic [11:0] HTC_OFS_FIFO = 12'h10C;
	localparam logic [11:0] HTC_OFS_BOC = 12'h10D;
	localparam logic [11:0] HTC_OFS_TXC2 = 12'h10E;
	localparam logic [11:0] HTC_OFS_STAT = 12'h10F;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int HTC_B1_FLAGS = 7;
	localparam int HTC_B1_LOOP = 6;
	localparam int HTC_B1_SRST = 5;
	localparam int HTC_B1_MAP = 4;
	localparam int HTC_B1_FILL = 3;
	localparam int HTC_B1_EOM = 2;
	localparam int HTC_B1_ZSD = 1;
	localparam int HTC_B1_CRCD = 0;
	localparam int HTC_B2_ABT = 7;
	localparam int HTC_B2_BOC = 6;
	localparam int HTC_B2_EN = 5;
	localparam int HTC_T2_MAPEN = 7;
	localparam int HTC_T2_T1 = 0;
	localparam logic [7:0] HTC_RST_CTRL1 = 8'h00;
	localparam logic [7:0] HTC_RST_SUPP = 8'h00;
	localparam logic [7:0] HTC_RST_CTRL2 = 8'h00;
	localparam logic [7:0] HTC_RST_TXC2 = 8'h00;

	// ----------------------------------------------------------------
	// Line codes and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] HTC_FLAG = 8'h7E;
	localparam logic [7:0] HTC_IDLE = 8'hFF;
	localparam logic [7:0] HTC_ABORT_BYTE = 8'hFE;
	localparam logic [15:0] HTC_CRC_INIT = 16'hFFFF;
	localparam logic [15:0] HTC_CRC_POLY = 16'h8408;
	localparam logic [2:0] HTC_STUFF_RUN = 3'h5;
	localparam logic [3:0] HTC_SRST_HOLD = 4'h8;
	localparam int HTC_CLK_NS = 10;
	localparam int HTC_SRST_MAX_NS = 250000;

	typedef enum logic [2:0] {
		HTC_FILL,
		HTC_OPEN,
		HTC_DATA,
		HTC_CRC,
		HTC_CLOSE,
		HTC_ABORT
	} htc_state_type;

endpackage

// File: src/htc_crc16.sv
module htc_crc16
	import htc_pkg::*;
(
	input wire logic i_clk, // Transmit clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_clear, // Restart at the opening of a message
	input wire logic i_en, // One message bit taken
	input wire logic i_bit, // That message bit
	output logic [15:0] o_crc_next // Remainder including this cycle's bit
);

	logic [15:0] crc_q;
	logic [15:0] crc_d;
	logic fb;

	// ----------------------------------------------------------------
	// Reflected CRC-16, one bit per step, LSB of each byte first
	// ----------------------------------------------------------------
	always_comb begin
		fb = crc_q[0] ^ i_bit;
		crc_d = crc_q;
		if (i_en) begin
			crc_d = {1'b0, crc_q[15:1]} ^ (fb ? HTC_CRC_POLY : 16'h0000);
		end
		o_crc_next = crc_d;
		if (i_clear) begin
			crc_d = HTC_CRC_INIT;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			crc_q <= HTC_CRC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end

endmodule

// File: src/htc_tx_controller.sv
// Notes on behaviour
// [RULE1] One flag between messages, two if selected
// [RULE2] Loop-marked message repeats until stopped
// [RULE3] Loop cleared: finish message, then flags
// [RULE4] New data ends loop, flags, new message
// [RULE5] Host marks end before writing last byte
// [RULE6] Two-byte CRC closes every message unless CRC defeat is set
// [RULE7] CRC defeat bit stops CRC generation
// [RULE8] Soft reset flushes, then abort and fill
// [RULE9] Soft reset bit self-clears, well under limit
// [RULE10] Map to chosen channel or data link
// [RULE11] Inter-message fill is 7E or FF
// [RULE12] Zero after five ones unless defeated
// [RULE13] Suppressed channel bit positions carry nothing
// [RULE14] Abort rise flushes, sends FE, then fill
// [RULE15] Host re-arms abort by clear then set
// [RULE16] T1 only: send six-bit oriented code
// [RULE17] Enable bit gates all transmission
// [RULE18] Channel select applies at soft reset
// [RULE19] Flags framing, LSB first, CRC on data
// [RULE20] Controls sampled in transmit clock domain
module htc_tx_controller
	import htc_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int AW = 6,
	parameter int SRST_MAX_CYC = HTC_SRST_MAX_NS / HTC_CLK_NS
) (
	input wire logic i_clk, // Framer transmit clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic [11:0] i_addr, // Register address
	input wire logic [7:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [7:0] o_rdata, // Read data, cycle after strobe
	input wire logic i_bit_req, // Framer asks for one line bit
	input wire logic [4:0] i_slot, // Current channel number
	input wire logic [2:0] i_bit_pos, // Bit in channel, 7 is MSB
	input wire logic i_dlink_slot, // Bit is a data-link or Sa bit
	output logic o_tx_bit, // Bit for the line
	output logic o_tx_valid // Pulse: o_tx_bit is ours
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] ctrl1_q, ctrl1_d, supp_q, supp_d, ctrl2_q, ctrl2_d;
	logic [7:0] txc2_q, txc2_d, rdata_q, rdata_d, ctrl1_rd;
	logic [5:0] boc_q, boc_d;
	logic [4:0] chan_q, chan_d;
	logic [3:0] srst_cnt_q, srst_cnt_d;
	logic abt_prev_q, abt_prev_d;
	logic srst_act, host_srst_wr, abort_rise, fifo_we, full, avail;

	// ----------------------------------------------------------------
	// Engine state
	// ----------------------------------------------------------------
	htc_state_type state_q, state_d;
	logic [15:0] sh_q, sh_d;
	logic [4:0] left_q, left_d;
	logic [2:0] ones_q, ones_d;
	logic [AW:0] wr_q, wr_d, rd_q, rd_d, start_q, start_d, fidx;
	logic [3:0] boc_idx_q, boc_idx_d;
	logic cur_eom_q, cur_eom_d, cur_loop_q, cur_loop_d;
	logic bit_q, bit_d, valid_q, valid_d;
	logic take, boc_on, boc_take, stuff_now, in_msg, fetch, crc_en, crc_clr;
	logic [15:0] crc_next, boc_pat;
	logic [9:0] mem_q [DEPTH];

	assign srst_act = srst_cnt_q != 4'h0;
	assign host_srst_wr = i_wr && i_addr == HTC_OFS_CTRL1 && i_wdata[HTC_B1_SRST];
	assign abort_rise = ctrl2_q[HTC_B2_ABT] && !abt_prev_q; // see [RULE14] see [RULE15]
	assign full = (wr_q - start_q) == (AW + 1)'(DEPTH);
	assign avail = rd_q != wr_q;
	assign fifo_we = i_wr && i_addr == HTC_OFS_FIFO && !full && !srst_act;
	assign ctrl1_rd = {ctrl1_q[7:6], srst_act, ctrl1_q[4:0]}; // see [RULE9]

	// Host and framer share one clock, so controls need no crossing
	// see [RULE20]
	always_comb begin
		ctrl1_d = ctrl1_q;
		supp_d = supp_q;
		ctrl2_d = ctrl2_q;
		txc2_d = txc2_q;
		boc_d = boc_q;
		chan_d = chan_q;
		abt_prev_d = ctrl2_q[HTC_B2_ABT];
		srst_cnt_d = srst_act ? srst_cnt_q - 4'h1 : 4'h0; // see [RULE9]
		if (srst_cnt_q == 4'h1) begin
			chan_d = ctrl2_q[4:0]; // see [RULE18]
		end
		// End mark is spent on the byte it tags
		if (fifo_we) begin
			ctrl1_d[HTC_B1_EOM] = 1'b0; // see [RULE5]
		end
		if (i_wr) begin
			case (i_addr)
				HTC_OFS_CTRL1: ctrl1_d = i_wdata;
				HTC_OFS_SUPP: supp_d = i_wdata;
				HTC_OFS_CTRL2: ctrl2_d = i_wdata;
				HTC_OFS_TXC2: txc2_d = i_wdata;
				HTC_OFS_BOC: boc_d = i_wdata[5:0];
				default: ;
			endcase
		end
		// A new request restarts the count even mid-reset
		if (host_srst_wr) begin
			srst_cnt_d = HTC_SRST_HOLD; // see [RULE8]
		end
		rdata_d = 8'h00;
		if (i_rd) begin
			case (i_addr)
				HTC_OFS_CTRL1: rdata_d = ctrl1_rd;
				HTC_OFS_SUPP: rdata_d = supp_q;
				HTC_OFS_CTRL2: rdata_d = ctrl2_q;
				HTC_OFS_TXC2: rdata_d = txc2_q;
				HTC_OFS_BOC: rdata_d = {2'b00, boc_q};
				HTC_OFS_STAT: rdata_d = {5'h00, full, !avail, state_q == HTC_FILL};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl1_q <= HTC_RST_CTRL1;
			supp_q <= HTC_RST_SUPP;
			ctrl2_q <= HTC_RST_CTRL2;
			txc2_q <= HTC_RST_TXC2;
			boc_q <= 6'h00;
			chan_q <= 5'h00;
			abt_prev_q <= 1'b0;
			srst_cnt_q <= 4'h0;
			rdata_q <= 8'h00;
		end else begin
			ctrl1_q <= ctrl1_d;
			supp_q <= supp_d;
			ctrl2_q <= ctrl2_d;
			txc2_q <= txc2_d;
			boc_q <= boc_d;
			chan_q <= chan_d;
			abt_prev_q <= abt_prev_d;
			srst_cnt_q <= srst_cnt_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Message store; looped message stays until it is released
	// ----------------------------------------------------------------
	for (genvar i = 0; i < DEPTH; i++) begin : g_mem
		always_ff @(posedge i_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				mem_q[i] <= 10'h000;
			end else if (fifo_we && wr_q[AW-1:0] == AW'(i)) begin
				mem_q[i] <= {ctrl1_q[HTC_B1_LOOP],
					ctrl1_q[HTC_B1_EOM] | ctrl1_q[HTC_B1_LOOP], i_wdata}; // see [RULE2]
			end
		end
	end

	// Slot selection: channel bits or data-link bits; the code word takes data-link bits in either mode
	assign boc_on = ctrl2_q[HTC_B2_BOC] && txc2_q[HTC_T2_T1]; // see [RULE16]
	assign boc_take = i_bit_req && ctrl2_q[HTC_B2_EN] && i_dlink_slot && boc_on;
	assign take = i_bit_req && ctrl2_q[HTC_B2_EN] && !srst_act && // see [RULE17]
		(ctrl1_q[HTC_B1_MAP] ?
		(txc2_q[HTC_T2_MAPEN] && i_dlink_slot && !boc_on) : // see [RULE10]
		(i_slot == chan_q && !supp_q[i_bit_pos])); // see [RULE13]
	// Code word sent LSB first: 0, six code bits, 0, eight ones
	assign boc_pat = {8'hFF, 1'b0, boc_q, 1'b0};
	assign in_msg = state_q == HTC_DATA || state_q == HTC_CRC;
	// Run of ones may end on the last CRC bit, so stuff before the flag too
	assign stuff_now = !ctrl1_q[HTC_B1_ZSD] && ones_q == HTC_STUFF_RUN; // see [RULE12]
	assign crc_en = take && !stuff_now && state_q == HTC_DATA; // see [RULE19]
	assign crc_clr = fetch && state_q != HTC_DATA;

	htc_crc16 u_crc (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_clear(crc_clr),
		.i_en(crc_en),
		.i_bit(sh_q[0]),
		.o_crc_next(crc_next)
	);

	// ----------------------------------------------------------------
	// Bit engine: flags, data, CRC, stuffing and fill
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		sh_d = sh_q;
		left_d = left_q;
		ones_d = ones_q;
		wr_d = fifo_we ? wr_q + 1'b1 : wr_q;
		rd_d = rd_q;
		start_d = start_q;
		cur_eom_d = cur_eom_q;
		cur_loop_d = cur_loop_q;
		boc_idx_d = boc_take ? boc_idx_q + 4'h1 : boc_idx_q;
		bit_d = boc_take ? boc_pat[boc_idx_q] : 1'b1; // see [RULE16]
		valid_d = take || boc_take;
		fetch = 1'b0;
		fidx = rd_q;
		if (take && stuff_now) begin
			bit_d = 1'b0;
			ones_d = 3'h0;
		end else if (take) begin
			bit_d = sh_q[0]; // see [RULE19]
			sh_d = {1'b0, sh_q[15:1]};
			left_d = left_q - 5'h1;
			ones_d = (in_msg && sh_q[0]) ? ones_q + 3'h1 : 3'h0;
			if (left_q == 5'h1) begin
				left_d = 5'h8;
				unique case (state_q)
					HTC_FILL, HTC_ABORT: begin
						state_d = avail ? HTC_OPEN : HTC_FILL;
						sh_d = {8'h00, avail ? HTC_FLAG : // see [RULE11]
							(ctrl1_q[HTC_B1_FILL] ? HTC_IDLE : HTC_FLAG)};
					end
					HTC_OPEN: fetch = 1'b1;
					HTC_DATA: begin
						if (cur_eom_q && ctrl1_q[HTC_B1_CRCD]) begin
							state_d = HTC_CLOSE; // see [RULE7]
							sh_d = {8'h00, HTC_FLAG};
						end else if (cur_eom_q) begin
							state_d = HTC_CRC; // see [RULE6]
							sh_d = ~crc_next;
							left_d = 5'h10;
						end else if (avail) begin
							fetch = 1'b1;
						end else begin
							// Host fell behind: abort rather than send a bad frame
							state_d = HTC_ABORT;
							sh_d = {8'h00, HTC_ABORT_BYTE};
						end
					end
					HTC_CRC: begin
						state_d = HTC_CLOSE;
						sh_d = {8'h00, HTC_FLAG};
					end
					HTC_CLOSE: begin
						// Replay only while loop bit holds and nothing new waits
						if (cur_loop_q && ctrl1_q[HTC_B1_LOOP] && !avail) begin
							fidx = start_q; // see [RULE2]
						end else begin
							start_d = rd_q; // see [RULE3] see [RULE4]
						end
						if (avail || fidx != rd_q) begin
							if (ctrl1_q[HTC_B1_FLAGS]) begin
								state_d = HTC_OPEN; // see [RULE1]
								sh_d = {8'h00, HTC_FLAG};
								rd_d = fidx;
							end else begin
								fetch = 1'b1;
							end
						end else begin
							state_d = HTC_FILL;
							sh_d = {8'h00, ctrl1_q[HTC_B1_FILL] ? HTC_IDLE : HTC_FLAG};
						end
					end
				endcase
			end
		end
		if (fetch) begin
			state_d = HTC_DATA;
			sh_d = {8'h00, mem_q[fidx[AW-1:0]][7:0]};
			cur_eom_d = mem_q[fidx[AW-1:0]][8];
			cur_loop_d = mem_q[fidx[AW-1:0]][9];
			rd_d = fidx + 1'b1;
		end
		// Flush wins over everything, including a write this cycle
		if (srst_act || abort_rise) begin
			state_d = HTC_ABORT; // see [RULE8] see [RULE14]
			sh_d = {8'h00, HTC_ABORT_BYTE};
			left_d = 5'h8;
			ones_d = 3'h0;
			wr_d = '0;
			rd_d = '0;
			start_d = '0;
			cur_loop_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= HTC_FILL;
			sh_q <= {8'h00, HTC_FLAG};
			left_q <= 5'h8;
			ones_q <= 3'h0;
			wr_q <= '0;
			rd_q <= '0;
			start_q <= '0;
			cur_eom_q <= 1'b0;
			cur_loop_q <= 1'b0;
			boc_idx_q <= 4'h0;
			bit_q <= 1'b1;
			valid_q <= 1'b0;
		end else begin
			state_q <= state_d;
			sh_q <= sh_d;
			left_q <= left_d;
			ones_q <= ones_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			start_q <= start_d;
			cur_eom_q <= cur_eom_d;
			cur_loop_q <= cur_loop_d;
			boc_idx_q <= boc_idx_d;
			bit_q <= bit_d;
			valid_q <= valid_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_tx_bit = bit_q;
	assign o_tx_valid = valid_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_srst_quiet;
		$rose(srst_act) && !host_srst_wr ##1 (!host_srst_wr)[*7];
	endsequence

	chk_srst_self_clear: assert property (s_srst_quiet |=> !srst_act) // see [RULE9]
		else $error("soft reset bit did not clear");
	chk_srst_limit: assert property (int'(srst_cnt_q) < SRST_MAX_CYC) // see [RULE9]
		else $error("soft reset too long");
	chk_chan_latch: assert property ($fell(srst_act) |-> chan_q == $past(ctrl2_q[4:0])) // see [RULE18]
		else $error("channel select not taken at reset end");
	chk_abort_flush: assert property (abort_rise |=> state_q == HTC_ABORT && // see [RULE14]
		sh_q[7:0] == HTC_ABORT_BYTE && wr_q == rd_q)
		else $error("abort did not flush and load FE");
	chk_stuff_zero: assert property (take && stuff_now |=> o_tx_valid && !o_tx_bit) // see [RULE12]
		else $error("missing stuffed zero");
	chk_crc_append: assert property (take && !stuff_now && left_q == 5'h1 && // see [RULE6]
		state_q == HTC_DATA && cur_eom_q && !ctrl1_q[HTC_B1_CRCD]
		|=> state_q == HTC_CRC && left_q == 5'h10)
		else $error("CRC not appended");
	chk_crc_defeat: assert property (take && !stuff_now && left_q == 5'h1 && // see [RULE7]
		state_q == HTC_DATA && cur_eom_q && ctrl1_q[HTC_B1_CRCD] |=> state_q == HTC_CLOSE)
		else $error("CRC sent while defeated");
	chk_disabled_quiet: assert property (!ctrl2_q[HTC_B2_EN] |=> !o_tx_valid) // see [RULE17]
		else $error("output while disabled");
	chk_suppress_bit: assert property (i_bit_req && !ctrl1_q[HTC_B1_MAP] && // see [RULE13]
		!i_dlink_slot && supp_q[i_bit_pos] |=> !o_tx_valid)
		else $error("suppressed bit position used");

endmodule

// File: tb/htc_line_model.sv
// Framer side: asks for one line bit every cycle, walking four channels
module htc_line_model (
	input wire logic i_clk, // Transmit clock
	input wire logic i_rstn, // Async reset, active low
	input wire logic i_clear, // Drop everything captured so far
	input wire logic i_tx_bit, // Bit from the controller
	input wire logic i_tx_valid, // Controller took the last request
	output logic o_bit_req, // Request for one bit
	output logic [4:0] o_slot, // Channel of the request
	output logic [2:0] o_bit_pos, // Bit in channel, 7 first
	output logic o_dlink_slot // Request is a data-link bit
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] cnt_q;
	logic [1:0] prev_slot_q;
	logic [2:0] prev_pos_q;
	logic [3:0] seen_slot;
	logic [7:0] seen_pos;
	bit bits[$];

	// Channel walk: only one channel in four can carry data, as on a real line
	assign o_slot = {3'h0, cnt_q[4:3]};
	assign o_bit_pos = ~cnt_q[2:0];
	assign o_dlink_slot = (cnt_q == 5'h1F);

	// Capture answered bits; the answer belongs to the request one edge back
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 5'h00;
			o_bit_req <= 1'b0;
			prev_slot_q <= 2'h0;
			prev_pos_q <= 3'h0;
			seen_slot <= 4'h0;
			seen_pos <= 8'h00;
		end else begin
			o_bit_req <= 1'b1;
			cnt_q <= cnt_q + 5'h01;
			prev_slot_q <= o_slot[1:0];
			prev_pos_q <= o_bit_pos;
			if (i_clear) begin
				bits.delete();
				seen_slot <= 4'h0;
				seen_pos <= 8'h00;
			end else if (i_tx_valid) begin
				bits.push_back(i_tx_bit);
				seen_slot[prev_slot_q] <= 1'b1;
				seen_pos[prev_pos_q] <= 1'b1;
			end
		end
	end
endmodule

// File: tb/test_htc_tx_controller.sv
module test_htc_tx_controller
	import htc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic clear = 1'b0;
	logic [7:0] rdata;
	logic bit_req;
	logic [4:0] slot;
	logic [2:0] pos;
	logic dlink;
	logic tx_bit;
	logic tx_valid;
	logic [7:0] d;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	bit want[$];

	htc_tx_controller u_dut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_bit_req(bit_req), .i_slot(slot),
		.i_bit_pos(pos), .i_dlink_slot(dlink), .o_tx_bit(tx_bit), .o_tx_valid(tx_valid));
	htc_line_model u_far (.i_clk(clk), .i_rstn(rstn), .i_clear(clear), .i_tx_bit(tx_bit),
		.i_tx_valid(tx_valid), .o_bit_req(bit_req), .o_slot(slot), .o_bit_pos(pos),
		.o_dlink_slot(dlink));

	// ----------------------------------------------------------------
	// Clock, watchdog and shared helpers
	// ----------------------------------------------------------------
	always #5 clk = ~clk;

	// Ceiling sits well above the roughly 20k cycles the scenarios need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			end_of_test();
		end
	end

	task end_of_test;
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 0;
		#1 v = rdata;
	endtask

	task clr;
		@(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
	endtask

	// Expected line bits, byte by byte, least significant bit first
	task wb(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			want.push_back(b[i]);
	endtask

	function automatic bit found();
		int n;
		n = want.size();
		for (int i = 0; i + n <= u_far.bits.size(); i++) begin
			int k;
			k = 0;
			while (k < n && u_far.bits[i + k] == want[k])
				k++;
			if (k == n)
				return 1'b1;
		end
		return 1'b0;
	endfunction

	function automatic logic [15:0] crc_of(input logic [7:0] b);
		logic [15:0] c;
		c = HTC_CRC_INIT;
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ HTC_CRC_POLY) : (c >> 1);
		return ~c;
	endfunction

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs;
		rd(HTC_OFS_CTRL1, d); check(d, HTC_RST_CTRL1);
		rd(HTC_OFS_CTRL2, d); check(d, HTC_RST_CTRL2);
		wr(HTC_OFS_SUPP, 8'hA5); rd(HTC_OFS_SUPP, d); check(d, 8'hA5);
		wr(12'h112, 8'h55); rd(12'h112, d); check(d, 8'h00);
		wr(HTC_OFS_SUPP, 8'h00);
	endtask

	task t_soft_reset;
		wr(HTC_OFS_CTRL2, 8'h22);
		wr(HTC_OFS_CTRL1, 8'h20);
		clr();
		rd(HTC_OFS_CTRL1, d); check(d[5], 1'b1);
		repeat (10) @(posedge clk);
		rd(HTC_OFS_CTRL1, d); check(d[5], 1'b0);
		repeat (1200) @(posedge clk);
		want.delete(); wb(HTC_ABORT_BYTE); wb(HTC_FLAG);
		check(32'(found()), 1);
		check(u_far.seen_slot, 4'h4);
	endtask

	task t_gating;
		wr(HTC_OFS_SUPP, 8'h81); clr(); repeat (600) @(posedge clk);
		check(u_far.seen_pos, 8'h7E);
		wr(HTC_OFS_SUPP, 8'h00); wr(HTC_OFS_CTRL2, 8'h21); clr(); repeat (300) @(posedge clk);
		check(u_far.seen_slot, 4'h4);
		wr(HTC_OFS_CTRL2, 8'h02); clr(); repeat (300) @(posedge clk);
		check(u_far.bits.size(), 0);
		wr(HTC_OFS_CTRL2, 8'h22);
	endtask

	task t_fill;
		wr(HTC_OFS_CTRL1, 8'h08); clr(); repeat (800) @(posedge clk);
		want.delete(); wb(HTC_IDLE); wb(HTC_IDLE);
		check(32'(found()), 1);
		wr(HTC_OFS_CTRL1, 8'h00); clr(); repeat (800) @(posedge clk);
		want.delete(); wb(HTC_FLAG); wb(HTC_FLAG);
		check(32'(found()), 1);
	endtask

	// Only a rising abort bit may produce a second abort byte
	task t_abort;
		// Clear the capture first so no abort bit is lost to it
		clr(); wr(HTC_OFS_CTRL2, 8'hA2); repeat (800) @(posedge clk);
		want.delete(); wb(HTC_ABORT_BYTE); wb(HTC_FLAG);
		check(32'(found()), 1);
		clr(); wr(HTC_OFS_CTRL2, 8'hA2); repeat (800) @(posedge clk);
		want.delete(); wb(HTC_ABORT_BYTE);
		check(32'(found()), 0);
		wr(HTC_OFS_CTRL2, 8'h22);
	endtask

	task t_message;
		logic [15:0] crc;
		crc = crc_of(8'h00);
		// End mark goes up before the last byte is written
		wr(HTC_OFS_CTRL1, 8'h06); clr();
		wr(HTC_OFS_FIFO, 8'h00); repeat (1500) @(posedge clk);
		want.delete(); wb(HTC_FLAG); wb(8'h00); wb(crc[7:0]); wb(crc[15:8]); wb(HTC_FLAG);
		check(32'(found()), 1);
		wr(HTC_OFS_CTRL1, 8'h05); clr(); wr(HTC_OFS_FIFO, 8'hFF); repeat (1200) @(posedge clk);
		// Five ones, stuffed zero, last three ones of the byte
		want.delete(); wb(HTC_FLAG); wb(8'hDF); want.push_back(1); wb(HTC_FLAG);
		check(32'(found()), 1);
		for (int nf = 0; nf < 2; nf++) begin
			wr(HTC_OFS_CTRL1, 8'h07 | (nf << 7)); clr(); wr(HTC_OFS_FIFO, 8'h00);
			wr(HTC_OFS_CTRL1, 8'h07 | (nf << 7)); wr(HTC_OFS_FIFO, 8'h00);
			repeat (2000) @(posedge clk);
			want.delete(); wb(8'h00); wb(HTC_FLAG);
			if (nf == 1)
				wb(HTC_FLAG);
			wb(8'h00);
			check(32'(found()), 1);
		end
	endtask

	task t_loop;
		wr(HTC_OFS_CTRL1, 8'h43); clr(); wr(HTC_OFS_FIFO, 8'h00); repeat (2000) @(posedge clk);
		want.delete(); wb(8'h00); wb(HTC_FLAG); wb(8'h00); wb(HTC_FLAG); wb(8'h00);
		check(32'(found()), 1);
		wr(HTC_OFS_CTRL1, 8'h03); repeat (600) @(posedge clk); clr(); repeat (1000) @(posedge clk);
		want.delete(); wb(8'h00);
		check(32'(found()), 0);
		// Loop bit cleared, then new data: current copy, one flag, then the new message
		wr(HTC_OFS_CTRL1, 8'h43); clr(); wr(HTC_OFS_FIFO, 8'h00); repeat (600) @(posedge clk);
		wr(HTC_OFS_CTRL1, 8'h07); wr(HTC_OFS_FIFO, 8'h55); repeat (600) @(posedge clk);
		want.delete(); wb(8'h00); wb(HTC_FLAG); wb(8'h55);
		check(32'(found()), 1);
	endtask

	task t_map;
		wr(HTC_OFS_TXC2, 8'h80); wr(HTC_OFS_CTRL1, 8'h10); clr(); repeat (600) @(posedge clk);
		check({u_far.seen_slot, u_far.seen_pos}, 12'h801);
		wr(HTC_OFS_BOC, 8'h2A); wr(HTC_OFS_TXC2, 8'h81); wr(HTC_OFS_CTRL2, 8'h62);
		clr(); repeat (1800) @(posedge clk);
		want.delete(); wb(8'h54); wb(HTC_IDLE);
		check(32'(found()), 1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_regs();
		t_soft_reset();
		t_gating();
		t_fill();
		t_abort();
		t_message();
		t_loop();
		t_map();
		end_of_test();
	end
endmodule
